// >>> logic/dec_link_if.sv
`timescale 1ns/10ps
interface dec_link_if;
  logic load;
  logic [scan_seq_pkg::SEQ_W-1:0] value;
  logic [scan_seq_pkg::SEQ_W-1:0] result;

  modport client (
    output load,
    output value,
    input result
  );

  modport unit (
    input load,
    input value,
    output result
  );
endinterface

// >>> logic/scan_address_sequencing.sv
`timescale 1ns/10ps
// Functional notes
// - Only one counter is stepped through the shared decrementer per cycle.
// - Source captured into hold latch on not-clock, result written back on clock.
// - The capturing not-clock slot also clears the sequencer when it is the source; the external counter is not cleared.
// - Decrementer output equals hold latch value minus one.
// - Sequencer loads from operand field, 21/23 by hardware, 7/8/21 by orders.
// - Fault-locating scan-in presets sequencer to 8, steps once per word.
// - Word fetched at sequencer value 1 supplies the new sequencer setting.
// - Scan-in completes when sequencer reaches zero; stepping is microprogram driven.
// - Scan-out word chosen from sequencer contents plus last word flag.
// - Logout starts at 21 or 23, steps once per doubleword.
// - Processor clock held stopped from start down to 14, released from 13.
// - First logout zero forces 21; then order sets 7, count to zero ends.
// - Decoder splits high two and low three bits into 21 gates.
// - Address bits 0-7, 9-14 and 21-23 are always zero.
// - Sequencer bits 0 and 1-4 drive address bits 15 and 17-20.
// - Logout puts inverse of sequencer bit 0 on bit 16, bit 8 zero.
// - Each new test goes to the buffer opposite the previous one.
// - During tests bit 16 is 0 with first-buffer flag set, else 1.
// - Flag toggles at test sequencer 5, or preset-retry order with test loaded.
// - During tests address bit 8 is always one.
// - Sequencer drives the address bus only while the scan-sync flag is set.
// - Logout area 80-128 hex, test buffers from 8000 and 8080 hex.
module scan_address_sequencing #(
  parameter int EXT_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fault_locating_test,
  input wire logic control_store_test,
  input wire logic logout_mode,
  input wire logic operand_load,
  input wire logic [4:0] operand_field,
  input wire logic hw_load_21,
  input wire logic hw_load_23,
  input wire logic order_load_7,
  input wire logic order_load_8,
  input wire logic order_load_21,
  input wire logic seq_step_req,
  input wire logic ext_step_req,
  input wire logic [EXT_W-1:0] ext_value,
  input wire logic last_word_flag,
  input wire logic [2:0] control_store_test_seq,
  input wire logic preset_retry_order,
  input wire logic test_loaded_pulse,
  input wire logic storage_request_scan_order,
  input wire logic storage_taken,
  output logic [EXT_W-1:0] ext_result,
  output logic ext_result_valid,
  output logic [4:0] addr_seq,
  output logic [20:0] scan_out_gate,
  output logic scan_out_last_word,
  output logic [23:0] storage_address_bus,
  output logic storage_address_valid,
  output logic cpu_clock_stop,
  output logic scan_in_complete,
  output logic logout_done,
  output logic buffer_first_sel
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (EXT_W < 1 || EXT_W > scan_seq_pkg::SEQ_W) begin : g_bad_width
      $error("EXT_W must lie between 1 and the hold latch width");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] seq;
    logic phase;
    scan_seq_pkg::dec_src_t sel;
    logic seq_pend;
    logic ext_pend;
    logic [EXT_W-1:0] ext_res;
    logic ext_valid;
    logic sync;
    logic buf1;
    logic [2:0] cs_prev;
    scan_seq_pkg::logout_state_t lo;
    logic lo_done;
    logic scan_done;
    logic last_wd;
  } seq_state_t;

  seq_state_t state_r;
  seq_state_t state_nxt;

  dec_link_if dec_link ();

  scan_decrementer u_dec (
    .clk(clk),
    .rst(rst),
    .link(dec_link.unit)
  );

  logic capture_slot;
  logic writeback_slot;
  logic grant_seq;
  logic grant_ext;
  logic [4:0] dec_out;
  logic any_test;
  logic cs_at_flip;
  logic cs_sync_hit;

  // ----------------------------------------------------------------
  // Shared decrement path arbitration
  // ----------------------------------------------------------------
  // Phase low stands for the not-clock slot, phase high for the clock
  // slot. A capture is only granted when no source is in flight, so a
  // second source can never be stepped before the first is written back.
  assign capture_slot = !state_r.phase && (state_r.sel == scan_seq_pkg::SRC_NONE);
  assign writeback_slot = state_r.phase;
  assign grant_seq = capture_slot && state_r.seq_pend;
  assign grant_ext = capture_slot && !state_r.seq_pend && state_r.ext_pend;

  always_comb begin
    dec_link.load = grant_seq || grant_ext;
    if (grant_seq) begin
      dec_link.value = state_r.seq;
    end else begin
      dec_link.value = scan_seq_pkg::SEQ_W'(ext_value);
    end
  end

  assign dec_out = dec_link.result;

  assign any_test = fault_locating_test || control_store_test;
  assign cs_at_flip = control_store_test_seq == scan_seq_pkg::CS_BUF_FLIP;
  assign cs_sync_hit = (control_store_test_seq == scan_seq_pkg::CS_SYNC_A)
                    || (control_store_test_seq == scan_seq_pkg::CS_SYNC_B)
                    || (control_store_test_seq == scan_seq_pkg::CS_SYNC_C);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.phase = !state_r.phase;
    state_nxt.lo_done = 1'b0;
    state_nxt.scan_done = 1'b0;
    state_nxt.ext_valid = 1'b0;
    state_nxt.last_wd = last_word_flag;

    // A request that arrives in its own grant cycle is kept pending.
    state_nxt.seq_pend = (state_r.seq_pend && !grant_seq) || seq_step_req;
    state_nxt.ext_pend = (state_r.ext_pend && !grant_ext) || ext_step_req;

    if (grant_seq) begin
      state_nxt.sel = scan_seq_pkg::SRC_SEQ;
      state_nxt.seq = scan_seq_pkg::SEQ_RESET;
    end else if (grant_ext) begin
      state_nxt.sel = scan_seq_pkg::SRC_EXT;
    end

    if (writeback_slot && state_r.sel == scan_seq_pkg::SRC_SEQ) begin
      state_nxt.sel = scan_seq_pkg::SRC_NONE;
      state_nxt.seq = dec_out;
      if (dec_out == scan_seq_pkg::SEQ_ZERO) begin
        if (fault_locating_test) begin
          state_nxt.scan_done = 1'b1;
        end
        case (state_r.lo)
          scan_seq_pkg::LO_DUMP: begin
            state_nxt.seq = scan_seq_pkg::SEQ_SET_21;
            state_nxt.lo = scan_seq_pkg::LO_REREAD;
          end
          scan_seq_pkg::LO_FINISH: begin
            state_nxt.lo = scan_seq_pkg::LO_IDLE;
            state_nxt.lo_done = 1'b1;
          end
          default: begin
            state_nxt.lo = state_r.lo;
          end
        endcase
      end
    end else if (writeback_slot && state_r.sel == scan_seq_pkg::SRC_EXT) begin
      state_nxt.sel = scan_seq_pkg::SRC_NONE;
      state_nxt.ext_res = dec_out[EXT_W-1:0];
      state_nxt.ext_valid = 1'b1;
    end

    // ----------------------------------------------------------------
    // Sequencer loads
    // ----------------------------------------------------------------
    // Loads give way to a step in flight so the written-back value is
    // never overrun by a load in the same slot. A write-back to the other
    // counter leaves the sequencer alone, so a load may land beside it.
    if (state_r.sel != scan_seq_pkg::SRC_SEQ && !grant_seq) begin
      if (operand_load) begin
        state_nxt.seq = operand_field;
      end else if (hw_load_21 || hw_load_23) begin
        state_nxt.seq = hw_load_23 ? scan_seq_pkg::SEQ_SET_23
                                   : scan_seq_pkg::SEQ_SET_21;
        if (logout_mode) begin
          state_nxt.lo = scan_seq_pkg::LO_DUMP;
        end
      end else if (order_load_8) begin
        state_nxt.seq = scan_seq_pkg::SEQ_SET_8;
      end else if (order_load_7) begin
        state_nxt.seq = scan_seq_pkg::SEQ_SET_7;
        if (state_r.lo == scan_seq_pkg::LO_REREAD) begin
          state_nxt.lo = scan_seq_pkg::LO_FINISH;
        end
      end else if (order_load_21) begin
        state_nxt.seq = scan_seq_pkg::SEQ_SET_21;
      end
    end

    if (!logout_mode) begin
      state_nxt.lo = scan_seq_pkg::LO_IDLE;
    end

    // ----------------------------------------------------------------
    // Buffer select flag
    // ----------------------------------------------------------------
    // The test sequencer may dwell at 5 for more than one cycle, so the
    // flag flips only on entry to 5 rather than on every cycle there.
    state_nxt.cs_prev = control_store_test_seq;
    if (control_store_test && cs_at_flip
        && state_r.cs_prev != scan_seq_pkg::CS_BUF_FLIP) begin
      state_nxt.buf1 = !state_r.buf1;
    end else if (fault_locating_test && preset_retry_order && test_loaded_pulse) begin
      state_nxt.buf1 = !state_r.buf1;
    end

    // ----------------------------------------------------------------
    // Scan-sync flag, set wins over the storage acknowledge
    // ----------------------------------------------------------------
    // The acknowledge takes the sequencer off the bus until the next
    // request, so a stale address is never offered to storage twice.
    if ((fault_locating_test || logout_mode) && storage_request_scan_order) begin
      state_nxt.sync = 1'b1;
    end else if (control_store_test && cs_sync_hit) begin
      state_nxt.sync = 1'b1;
    end else if (storage_taken) begin
      state_nxt.sync = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '{
        seq: scan_seq_pkg::SEQ_RESET,
        phase: 1'b0,
        sel: scan_seq_pkg::SRC_NONE,
        seq_pend: 1'b0,
        ext_pend: 1'b0,
        ext_res: '0,
        ext_valid: 1'b0,
        sync: 1'b0,
        buf1: scan_seq_pkg::BUF1_RESET,
        cs_prev: scan_seq_pkg::CS_SEQ_RESET,
        lo: scan_seq_pkg::LO_IDLE,
        lo_done: 1'b0,
        scan_done: 1'b0,
        last_wd: 1'b0
      };
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scan-out decoder
  // ----------------------------------------------------------------
  logic [3:0] hi_dec;
  logic [7:0] lo_dec;

  // Only 21 gate lines exist, so counts 21 to 31 raise no gate at all.
  // Those words are reached through the storage address alone, and a
  // user who scans out above 20 sees an empty word.
  always_comb begin
    hi_dec = 4'h0;
    lo_dec = 8'h00;
    hi_dec[state_r.seq[4:3]] = 1'b1;
    lo_dec[state_r.seq[2:0]] = 1'b1;
  end

  generate
    for (genvar g = 0; g < scan_seq_pkg::GATE_COUNT; g++) begin : g_gate
      assign scan_out_gate[g] = hi_dec[g / 8] && lo_dec[g % 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Storage address generator
  // ----------------------------------------------------------------
  // Bit numbers count from the most significant end, so bus bit n sits
  // at vector position 23 - n. Every other bit stays zero, which keeps
  // each access on a doubleword boundary.
  always_comb begin
    storage_address_bus = 24'h000000;
    if (state_r.sync) begin
      storage_address_bus[23 - scan_seq_pkg::BUS_SEQ_HI_BIT] = state_r.seq[4];
      storage_address_bus[23 - scan_seq_pkg::BUS_SEQ_LO_BIT -: 4] = state_r.seq[3:0];
      if (any_test) begin
        storage_address_bus[23 - scan_seq_pkg::BUS_AREA_BIT] = 1'b1;
        storage_address_bus[23 - scan_seq_pkg::BUS_BUF_BIT] = !state_r.buf1;
      end else begin
        storage_address_bus[23 - scan_seq_pkg::BUS_BUF_BIT] = !state_r.seq[4];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign storage_address_valid = state_r.sync;
  assign addr_seq = state_r.seq;
  assign scan_out_last_word = state_r.last_wd;
  assign ext_result = state_r.ext_res;
  assign ext_result_valid = state_r.ext_valid;
  assign buffer_first_sel = state_r.buf1;
  assign scan_in_complete = state_r.scan_done;
  assign logout_done = state_r.lo_done;

  // ----------------------------------------------------------------
  // Processor clock stop
  // ----------------------------------------------------------------
  // While a step is in flight the sequencer shows its cleared value, so
  // the count about to land is judged instead. Without this the clock
  // would slip free for one cycle on every step from a count of 14 or more.
  logic stop_count_high;

  always_comb begin
    if (state_r.sel == scan_seq_pkg::SRC_SEQ) begin
      stop_count_high = (dec_out >= scan_seq_pkg::SEQ_CLOCK_STOP_LOW - scan_seq_pkg::DEC_STEP);
    end else begin
      stop_count_high = (state_r.seq >= scan_seq_pkg::SEQ_CLOCK_STOP_LOW);
    end
  end

  // The clock is released once the sequencer holds a count below 14, so
  // the writeback slot that lands 13 still keeps the processor stopped.
  assign cpu_clock_stop = (state_r.lo == scan_seq_pkg::LO_DUMP) && stop_count_high;

endmodule

// >>> logic/scan_decrementer.sv
`timescale 1ns/10ps
module scan_decrementer (
  input wire logic clk,
  input wire logic rst,
  dec_link_if.unit link
);

  typedef struct packed {
    logic [scan_seq_pkg::SEQ_W-1:0] hold;
  } dec_state_t;

  dec_state_t state_r;
  dec_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (link.load) begin
      state_nxt.hold = link.value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Five-bit wrap is intended: a zero source comes back as all ones.
  assign link.result = state_r.hold - scan_seq_pkg::DEC_STEP;

endmodule

// >>> logic/scan_seq_pkg.sv
package scan_seq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SEQ_W = 5;
  localparam int ADDR_BUS_W = 24;
  localparam int GATE_COUNT = 21;
  localparam int CS_SEQ_W = 3;

  // ----------------------------------------------------------------
  // Fixed address sequencer settings
  // ----------------------------------------------------------------
  localparam logic [4:0] SEQ_RESET = 5'h00;
  localparam logic [4:0] SEQ_SET_7 = 5'h07;
  localparam logic [4:0] SEQ_SET_8 = 5'h08;
  localparam logic [4:0] SEQ_SET_21 = 5'h15;
  localparam logic [4:0] SEQ_SET_23 = 5'h17;
  localparam logic [4:0] SEQ_ZERO = 5'h00;
  localparam logic [4:0] SEQ_CLOCK_STOP_LOW = 5'h0e;
  localparam logic [4:0] DEC_STEP = 5'h01;

  // ----------------------------------------------------------------
  // Control-store test sequencer values
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_SYNC_A = 3'h1;
  localparam logic [2:0] CS_SYNC_B = 3'h3;
  localparam logic [2:0] CS_SYNC_C = 3'h6;
  localparam logic [2:0] CS_BUF_FLIP = 3'h5;
  localparam logic [2:0] CS_SEQ_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Storage address bus bit numbers, bit 0 is the most significant
  // ----------------------------------------------------------------
  localparam int BUS_AREA_BIT = 8;
  localparam int BUS_SEQ_HI_BIT = 15;
  localparam int BUS_BUF_BIT = 16;
  localparam int BUS_SEQ_LO_BIT = 17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic BUF1_RESET = 1'b1;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_SEQ,
    SRC_EXT
  } dec_src_t;

  typedef enum logic [1:0] {
    LO_IDLE,
    LO_DUMP,
    LO_REREAD,
    LO_FINISH
  } logout_state_t;

endpackage

// >>> tb/scan_seq_asserts.sv
`timescale 1ns/10ps
module scan_seq_asserts #(
  parameter int EXT_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fault_locating_test,
  input wire logic control_store_test,
  input wire logic logout_mode,
  input wire logic storage_request_scan_order,
  input wire logic [2:0] control_store_test_seq,
  input wire logic preset_retry_order,
  input wire logic test_loaded_pulse,
  input wire logic [EXT_W-1:0] ext_value,
  input wire logic [EXT_W-1:0] ext_result,
  input wire logic ext_result_valid,
  input wire logic [4:0] addr_seq,
  input wire logic [20:0] scan_out_gate,
  input wire logic [23:0] storage_address_bus,
  input wire logic storage_address_valid,
  input wire logic buffer_first_sel
);
  // ----------------------------------------------------------------
  // Address bus, decoder and decrementer
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire [23:0] adr = storage_address_bus;
  wire sync = storage_address_valid;
  wire test_on = (fault_locating_test | control_store_test) & ~logout_mode;

  zero_bits_a: assert property ((adr & 24'hff7e07) == 24'h000000)
    else $error("scan address has a forced zero bit set");
  seq_bus_a: assert property (sync |-> {adr[8], adr[6:3]} == addr_seq)
    else $error("sequencer bits misplaced on address bus");
  logout_bit_a: assert property (
    sync && logout_mode |-> adr[7] == !addr_seq[4] && !adr[15])
    else $error("logout address area bits wrong");
  buf_bit_a: assert property (
    sync && test_on |-> adr[7] == !buffer_first_sel && adr[15])
    else $error("test buffer address bits wrong");
  bus_gate_a: assert property (!sync |-> adr == 24'h000000)
    else $error("address bus driven without scan sync");
  sync_set_a: assert property (
    (storage_request_scan_order && (fault_locating_test || logout_mode)) ||
    (control_store_test && control_store_test_seq inside {3'h1, 3'h3, 3'h6}) |=> sync)
    else $error("scan sync not set by its cause");
  gate_dec_a: assert property (
    scan_out_gate == (addr_seq <= 5'h14 ? 21'h000001 << addr_seq : 21'h000000))
    else $error("scan-out gate decode wrong");
  ext_dec_a: assert property (
    ext_result_valid |-> ext_result == EXT_W'(ext_value - 1'b1))
    else $error("decrementer result is not value minus one");
  buf_flip_a: assert property ($changed(buffer_first_sel) |->
    $past(control_store_test && control_store_test_seq == 3'h5) ||
    $past(fault_locating_test && preset_retry_order && test_loaded_pulse))
    else $error("buffer flag changed without cause");
endmodule

bind scan_address_sequencing scan_seq_asserts #(.EXT_W(EXT_W)) chk (
  .clk(clk), .rst(rst), .fault_locating_test(fault_locating_test),
  .control_store_test(control_store_test), .logout_mode(logout_mode),
  .storage_request_scan_order(storage_request_scan_order),
  .control_store_test_seq(control_store_test_seq), .preset_retry_order(preset_retry_order),
  .test_loaded_pulse(test_loaded_pulse), .ext_value(ext_value), .ext_result(ext_result),
  .ext_result_valid(ext_result_valid), .addr_seq(addr_seq), .scan_out_gate(scan_out_gate),
  .storage_address_bus(storage_address_bus), .storage_address_valid(storage_address_valid),
  .buffer_first_sel(buffer_first_sel));

// >>> tb/storage_partner.sv
`timescale 1ns/10ps
module storage_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lag,
  input wire logic logout_mode,
  input wire logic storage_address_valid,
  input wire logic [23:0] storage_address_bus,
  output logic storage_taken,
  output logic addr_bad
);
  // ----------------------------------------------------------------
  // Storage acceptance
  // ----------------------------------------------------------------
  // A long lag keeps the request standing, so a drifting bus shows as a bad address.
  logic [3:0] wait_cnt = 4'h0;
  logic [23:0] a;
  assign a = storage_address_bus;
  initial storage_taken = 1'b0;
  initial addr_bad = 1'b0;
  always @(negedge clk) begin
    storage_taken <= 1'b0;
    if (!rst && storage_address_valid) begin
      wait_cnt <= (wait_cnt == lag) ? 4'h0 : wait_cnt + 4'h1;
      storage_taken <= (wait_cnt == lag);
      if (logout_mode ? (a < 24'h80 || a > 24'h128) : (a < 24'h8000 || a > 24'h80c8)) begin
        addr_bad <= 1'b1;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  typedef struct packed {logic lm; logic [4:0] s; logic [23:0] a;} row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ft = 1'b0, cs = 1'b0, lo = 1'b0, op_ld = 1'b0, h21 = 1'b0, h23 = 1'b0, o7 = 1'b0;
  logic o8 = 1'b0, o21 = 1'b0, sreq = 1'b0, ereq = 1'b0, lastw_in = 1'b0, retry = 1'b0;
  logic tlp = 1'b0, sro = 1'b0, taken, bad, ext_ok, lastw_out, sav, stop, sic, ldone, b1;
  logic [4:0] opf = 5'h00, ev = 5'h00, seq, eres;
  logic [2:0] tseq = 3'h0;
  logic [3:0] lag = 4'h0;
  logic [20:0] gate;
  logic [23:0] bus_addr;
  logic [2:0] sync_codes [3] = '{3'h1, 3'h3, 3'h6};
  row_t rows [7] = '{'{1'b1, 5'h15, 24'h000128}, '{1'b1, 5'h00, 24'h000080},
    '{1'b1, 5'h0f, 24'h0000f8}, '{1'b1, 5'h10, 24'h000100}, '{1'b0, 5'h08, 24'h008040},
    '{1'b0, 5'h01, 24'h008008}, '{1'b0, 5'h09, 24'h008048}};
  int error_cnt = 0, n_checks = 0, sic_n = 0, done_n = 0;

  always #12.5 clk = ~clk;

  scan_address_sequencing #(.EXT_W(5)) dut (
    .clk(clk), .rst(rst), .fault_locating_test(ft), .control_store_test(cs),
    .logout_mode(lo), .operand_load(op_ld), .operand_field(opf), .hw_load_21(h21),
    .hw_load_23(h23), .order_load_7(o7), .order_load_8(o8), .order_load_21(o21),
    .seq_step_req(sreq), .ext_step_req(ereq), .ext_value(ev), .last_word_flag(lastw_in),
    .control_store_test_seq(tseq), .preset_retry_order(retry), .test_loaded_pulse(tlp),
    .storage_request_scan_order(sro), .storage_taken(taken), .ext_result(eres),
    .ext_result_valid(ext_ok), .addr_seq(seq), .scan_out_gate(gate),
    .scan_out_last_word(lastw_out), .storage_address_bus(bus_addr), .storage_address_valid(sav),
    .cpu_clock_stop(stop), .scan_in_complete(sic), .logout_done(ldone),
    .buffer_first_sel(b1));
  storage_partner mem (.clk(clk), .rst(rst), .lag(lag), .logout_mode(lo),
    .storage_address_valid(sav), .storage_address_bus(bus_addr), .storage_taken(taken),
    .addr_bad(bad));

  always @(posedge clk) begin
    if (sic === 1'b1) sic_n++;
    if (ldone === 1'b1) done_n++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic settle;
    for (int i = 0; i < 20 && sav !== 1'b0; i++) @(negedge clk);
    check(sav, 1'b0);
  endtask

  // The cleared slot must be seen before the new value, and the task idles two cycles after the write-back.
  task automatic step(input logic [4:0] exp);
    logic z;
    z = 1'b0;
    pulse(sreq);
    for (int i = 0; i < 8; i++) begin
      if (z && seq === exp) break;
      if (seq === 5'h00) z = 1'b1;
      @(negedge clk);
    end
    check({z, seq}, {1'b1, exp});
    repeat (2) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    check(seq, 5'h00);
    check(b1, 1'b1);
    check(gate, 21'h000001);
    check(bus_addr, 24'h000000);
    foreach (rows[i]) begin
      lag = 4'(i);
      lo = rows[i].lm;
      ft = !rows[i].lm;
      opf = rows[i].s;
      pulse(op_ld);
      pulse(sro);
      check(seq, rows[i].s);
      check(bus_addr, rows[i].a);
      check(gate, 21'(21'h000001 << rows[i].s));
      settle();
    end
    check(bad, 1'b0);
    lo = 1'b0;
    ft = 1'b0;
    pulse(o21);
    sreq = 1'b1;
    pulse(ereq);
    sreq = 1'b0;
    for (int i = 0; i < 12 && ext_ok !== 1'b1; i++) @(negedge clk);
    check(ext_ok, 1'b1);
    check(eres, 5'h1f);
    for (int i = 0; i < 12 && seq !== 5'h14; i++) @(negedge clk);
    check(seq, 5'h14);
    ft = 1'b1;
    pulse(o8);
    check(seq, 5'h08);
    for (int k = 7; k > 0; k--) step(5'(k));
    opf = 5'h02;
    pulse(op_ld);
    check(seq, 5'h02);
    step(5'h01);
    step(5'h00);
    check(24'(sic_n), 24'h000001);
    ft = 1'b0;
    lo = 1'b1;
    pulse(h23);
    check({stop, seq}, {1'b1, 5'h17});
    for (int k = 22; k > 0; k--) begin
      step(5'(k));
      check(stop, k > 13);
    end
    step(5'h15);
    pulse(o7);
    for (int k = 6; k >= 0; k--) step(5'(k));
    check(24'(done_n), 24'h000001);
    lo = 1'b0;
    cs = 1'b1;
    tseq = 3'h5;
    repeat (2) @(negedge clk);
    check(b1, 1'b0);
    foreach (sync_codes[j]) begin
      tseq = sync_codes[j];
      @(negedge clk);
      check(bus_addr, 24'h008080);
      tseq = 3'h0;
      settle();
    end
    cs = 1'b0;
    ft = 1'b1;
    pulse(retry);
    check(b1, 1'b0);
    @(negedge clk);
    tlp = 1'b1;
    pulse(retry);
    tlp = 1'b0;
    check(b1, 1'b1);
    lastw_in = 1'b1;
    @(negedge clk);
    check(lastw_out, 1'b1);
    check(bad, 1'b0);
    wrap_up();
  end

  // The whole sequence needs under four hundred cycles; this allows 8000, over twenty times that.
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
endmodule
